/* File: inc/fplio_pkg.sv */
// Constants, register map and mode codes for the front-panel line block.
// Assumes one 125 MHz clock and a simple word register port on the board.
// Functional notes
// RL1 - Register mode input: read returns sampled levels.
// RL2 - Register mode output: lines drive written levels.
// RL3 - Trigger mode output carries four channel requests.
// RL4 - Busy is near-full or enabled hold-off input.
// RL5 - Near-full when occupancy reaches 12-bit threshold.
// RL6 - Enabled inhibit input suppresses the global trigger.
// RL7 - Handshake veto output copies inhibit input.
// RL8 - Enabled external fire input is a real trigger.
// RL9 - Handshake fire output copies connector trigger; the code drives the inverse of the connector trigger.
// RL10 - Start source 11 starts from acquisition go.
// RL11 - Control bit picks level or edge start.
// RL12 - Handshake run output is inverse of run.
// RL13 - Legacy input is only timestamp clear.
// RL14 - Legacy busy is inverse of low busy.
// RL15 - Zero threshold, no hold-off: busy equals full.
// RL16 - Legacy readout-available high while events stored.
// RL17 - Legacy trigger copies the channel global trigger.
// RL18 - Legacy run is inverse of low run.
// RL19 - Software clear or pin pulse clears buffer.
// RL20 - Time tag reset pulse reinitialises time tag.
// RL21 - Four direction bits, one per group.
// RL22 - Group modes only when control bit 8 set.
// RL23 - Four-bit group mode codes at 0,4,8,12.
// RL24 - All sixteen lines latched on every trigger.
// RL25 - Front-panel inputs pass a two-stage synchroniser.
// RL26 - Active-low outputs rest high after reset.
package fplio_pkg;
   localparam logic [15:0] ACQ_CONTROL_OFS = 16'h8100;
   localparam logic [15:0] LVDS_PIN_LEVEL_OFS = 16'h8118;
   localparam logic [15:0] FP_CONTROL_OFS = 16'h811C;
   localparam logic [15:0] SW_CLEAR_OFS = 16'h8120;
   localparam logic [15:0] BUFFER_FULL_THRESHOLD_OFS = 16'h816C;
   localparam logic [15:0] GROUP_MODE_OFS = 16'h81A0;

   localparam int ACQ_START_LSB = 0;
   localparam int ACQ_SW_RUN_BIT = 2;
   localparam int ACQ_HOLD_OFF_EN_BIT = 8;
   localparam int ACQ_INHIBIT_EN_BIT = 9;
   localparam int ACQ_GO_EDGE_BIT = 11;
   localparam logic [1:0] START_FROM_GO = 2'h3;

   localparam int FP_FIRE_EN_BIT = 0;
   localparam int FP_DIR_LSB = 2;
   localparam int FP_MODES_EN_BIT = 8;

   localparam int GRP_MODE_W = 4;
   localparam int GRP_HOLD_OFF = 0;
   localparam int GRP_INHIBIT = 1;
   localparam int GRP_FIRE = 2;
   localparam int GRP_GO = 3;

   localparam logic [31:0] ACQ_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] FP_CONTROL_RST = 32'h0000_0000;
   localparam logic [15:0] GROUP_MODE_RST = 16'h0000;
   localparam logic [15:0] PIN_LEVEL_RST = 16'h0000;
   localparam logic [11:0] THRESHOLD_RST = 12'h000;
   localparam logic [15:0] LINE_OUT_RST = 16'hFFFF;
   localparam logic [15:0] LEGACY_OE = 16'h0FFF;
   localparam int LEG_TT_CLEAR_LINE = 12;
   localparam int LEG_MEM_CLEAR_LINE = 13;

   typedef enum logic [3:0] {
      FPLIO_REGISTER = 4'h0,
      FPLIO_TRIGGER = 4'h1,
      FPLIO_HANDSHAKE = 4'h2,
      FPLIO_LEGACY = 4'h3
   } fplio_mode_t;
endpackage

/* File: rtl/fplio_sync.sv */
// Two-stage synchroniser for a bus of independent levels.
// Assumes each bit is an unrelated level; no word coherence is offered.
module fplio_sync #(
   parameter int WIDTH = 16
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_r;

   if (WIDTH < 1) begin : gChk
      $error("fplio_sync needs WIDTH of at least one");
   end

   // Idle front-panel lines are pulled high, so reset to the inactive level.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         meta_r <= '1;
         syncOut <= '1;
      end else begin
         meta_r <= asyncIn;
         syncOut <= meta_r;
      end
   end
endmodule

/* File: rtl/fplio_top.sv */
// Front-panel sixteen-line I/O block: four groups of four lines with modes.
// Assumes a word register port from the board controller and acquisition
// status and trigger signals from the rest of the digitiser.
module fplio_top #(
   parameter int LINES = 16,
   parameter int THR_W = 12
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [15:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regWrData,
   output logic [31:0] regRdData,
   output logic regRdValid,
   input wire logic [15:0] lineIn,
   output logic [15:0] lineOut,
   output logic [15:0] lineOe,
   input wire logic [7:0] chanTrigReq,
   input wire logic srcTrigIn,
   input wire logic [11:0] bufOccupancy,
   input wire logic memFullIn,
   input wire logic eventsStored,
   output logic globalTrig,
   output logic fireOutConnector,
   output logic runState,
   output logic memClear,
   output logic timeTagClear,
   output logic [31:0] eventTimeTag,
   output logic [15:0] eventPattern
);
   import fplio_pkg::*;

   localparam int GROUPS = LINES / 4;

   if (LINES != 16 || THR_W != 12) begin : gChk
      $error("fplio_top serves exactly sixteen lines and a 12-bit threshold");
   end

   logic [31:0] acqControl_r;
   logic [31:0] fpControl_r;
   logic [15:0] groupMode_r;
   logic [15:0] pinLevel_r;
   logic [11:0] threshold_r;
   logic [15:0] lineSync;
   logic [15:0] lineSyncPrev_r;
   logic runState_r;
   logic [15:0] lineOutNxt;
   logic [15:0] lineOeNxt;
   logic [31:0] rdDataNxt;

   function automatic fplio_mode_t modeOf(input logic [15:0] modes, input int g);
      modeOf = fplio_mode_t'(modes[g*GRP_MODE_W +: GRP_MODE_W]);
   endfunction

   // Every line is a raw pin; nothing downstream looks at the first stage.
   fplio_sync #(
      .WIDTH(16)
   ) uSync (
      .core_clk(core_clk),
      .resetn(resetn),
      .asyncIn(lineIn),
      .syncOut(lineSync) // RL25
   );

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lineSyncPrev_r <= '1;
      end else begin
         lineSyncPrev_r <= lineSync;
      end
   end

   // Falling edges of the synchronised lines: all front-panel inputs are active low.
   wire [15:0] lineFall = lineSyncPrev_r & ~lineSync;

   // Configuration decode.
   wire modesEn = fpControl_r[FP_MODES_EN_BIT]; // RL22
   wire [3:0] groupDirOut = fpControl_r[FP_DIR_LSB +: 4]; // RL21
   wire [1:0] startSel = acqControl_r[ACQ_START_LSB +: 2];
   wire holdOffInputEn = acqControl_r[ACQ_HOLD_OFF_EN_BIT];
   wire inhibitEn = acqControl_r[ACQ_INHIBIT_EN_BIT];
   wire goEdgeMode = acqControl_r[ACQ_GO_EDGE_BIT];
   wire fireEn = fpControl_r[FP_FIRE_EN_BIT];

   // Per-group input functions collected from groups set as inputs.
   // A function set up on more than one group is the OR of all of them, so
   // two handshake input groups drive one shared set of requests.
   logic [GROUPS-1:0] grpHoldOff;
   logic [GROUPS-1:0] grpInhibit;
   logic [GROUPS-1:0] grpFireFall;
   logic [GROUPS-1:0] grpGo;
   logic [GROUPS-1:0] grpGoFall;
   logic [GROUPS-1:0] grpTtClear;

   for (genvar g = 0; g < GROUPS; g++) begin : gIn
      wire isHsIn = modesEn && !groupDirOut[g] && modeOf(groupMode_r, g) == FPLIO_HANDSHAKE;
      wire isLegIn = modesEn && !groupDirOut[g] && modeOf(groupMode_r, g) == FPLIO_LEGACY;
      assign grpHoldOff[g] = isHsIn && !lineSync[4*g + GRP_HOLD_OFF];
      assign grpInhibit[g] = isHsIn && !lineSync[4*g + GRP_INHIBIT];
      assign grpFireFall[g] = isHsIn && lineFall[4*g + GRP_FIRE];
      assign grpGo[g] = isHsIn && !lineSync[4*g + GRP_GO];
      assign grpGoFall[g] = isHsIn && lineFall[4*g + GRP_GO];
      // Only the lowest line of a legacy input group has a function.
      assign grpTtClear[g] = isLegIn && lineFall[4*g]; // RL13
   end

   wire holdOffRequestIn = |grpHoldOff;
   wire inhibitRequestIn = |grpInhibit;
   wire extFireIn = |grpFireFall;
   wire acqGoIn = |grpGo;
   wire acqGoFall = |grpGoFall;

   // A zero threshold falls back to the plain memory-full flag.
   wire nearFull = (threshold_r == '0) ? memFullIn : (bufOccupancy >= threshold_r); // RL5 RL15
   wire busy = nearFull | (holdOffRequestIn & holdOffInputEn); // RL4
   wire holdOffOutLow = ~busy; // RL4
   wire inhibitOutLow = ~inhibitRequestIn; // RL7

   // Trigger sources; the connector copy ignores the veto so other boards
   // still see what this board asked for.
   wire fireSrc = srcTrigIn | (extFireIn & fireEn); // RL8
   wire vetoActive = inhibitRequestIn & inhibitEn; // RL6
   wire globalTrigNxt = fireSrc & runState_r & ~vetoActive; // RL6 RL8
   wire fireOutConnectorNxt = fireSrc & runState_r;

   // Run control: start source 11 follows the go line, by level or by edge.
   // An edge-started run is held until the start source or bit 11 is changed, since the
   // go line itself carries no stop in that mode.
   wire swRun = acqControl_r[ACQ_SW_RUN_BIT];
   logic runNxt;
   always_comb begin
      runNxt = swRun;
      if (startSel == START_FROM_GO) begin // RL10
         if (goEdgeMode) begin // RL11
            runNxt = runState_r | acqGoFall;
         end else begin
            runNxt = acqGoIn;
         end
      end
   end

   // Clear paths: in the default map lines 12 and 13 carry the clears.
   wire swClearWr = regWrEn && regAddr == SW_CLEAR_OFS;
   wire memClearNxt = swClearWr | (!modesEn & lineFall[LEG_MEM_CLEAR_LINE]); // RL19
   wire ttClearNxt = modesEn ? |grpTtClear : lineFall[LEG_TT_CLEAR_LINE]; // RL20

   // Output selection per group.
   wire [3:0] hsOut = {~runState_r, ~fireOutConnector, inhibitOutLow, holdOffOutLow}; // RL9 RL12
   wire [3:0] legOut = {runState_r, globalTrig, eventsStored, busy}; // RL14 RL16 RL17 RL18
   logic [15:0] modeOut;
   logic [15:0] modeOe;

   for (genvar g = 0; g < GROUPS; g++) begin : gOut
      fplio_mode_t gm;
      logic [3:0] o;
      assign gm = modeOf(groupMode_r, g);
      always_comb begin
         unique case (gm)
            FPLIO_REGISTER: o = pinLevel_r[4*g +: 4]; // RL2
            FPLIO_TRIGGER: o = chanTrigReq[4*(g % 2) +: 4]; // RL3
            FPLIO_HANDSHAKE: o = hsOut;
            FPLIO_LEGACY: o = legOut;
            default: o = 4'hF;
         endcase
      end
      assign modeOut[4*g +: 4] = groupDirOut[g] ? o : 4'hF;
      assign modeOe[4*g +: 4] = {4{groupDirOut[g]}}; // RL21
   end

   // Fixed map used while group modes are off.
   wire [15:0] legacyOut = {4'hF, runState_r, globalTrig, eventsStored, memFullIn, chanTrigReq};

   assign lineOutNxt = modesEn ? modeOut : legacyOut; // RL22
   assign lineOeNxt = modesEn ? modeOe : LEGACY_OE;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         lineOut <= LINE_OUT_RST; // RL26
         lineOe <= LEGACY_OE;
      end else begin
         lineOut <= lineOutNxt;
         lineOe <= lineOeNxt;
      end
   end

   // Trigger, run and clear strobes.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         runState_r <= 1'b0;
         globalTrig <= 1'b0;
         fireOutConnector <= 1'b0;
         memClear <= 1'b0;
         timeTagClear <= 1'b0;
      end else begin
         runState_r <= runNxt;
         globalTrig <= globalTrigNxt;
         fireOutConnector <= fireOutConnectorNxt;
         memClear <= memClearNxt;
         timeTagClear <= ttClearNxt;
      end
   end
   assign runState = runState_r;

   // Time tag counts while running; the clear strobe wins over counting.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         eventTimeTag <= '0;
      end else if (ttClearNxt) begin
         eventTimeTag <= '0; // RL20
      end else if (runState_r) begin
         eventTimeTag <= eventTimeTag + 32'h0000_0001;
      end
   end

   // Pattern capture happens whatever the group modes are.
   // The pattern trails the pins by the two synchroniser stages, so a pulse
   // shorter than one clock period may not show in it.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         eventPattern <= '0;
      end else if (globalTrigNxt) begin
         eventPattern <= lineSync; // RL24
      end
   end

   // Register writes: one decoded strobe per register keeps each process short.
   // Unmapped offsets match no strobe, so a stray write changes nothing.
   wire wrAcqControl = regWrEn && regAddr == ACQ_CONTROL_OFS;
   wire wrFpControl = regWrEn && regAddr == FP_CONTROL_OFS;
   wire wrGroupMode = regWrEn && regAddr == GROUP_MODE_OFS;
   wire wrPinLevel = regWrEn && regAddr == LVDS_PIN_LEVEL_OFS;
   wire wrThreshold = regWrEn && regAddr == BUFFER_FULL_THRESHOLD_OFS;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         acqControl_r <= ACQ_CONTROL_RST;
      end else if (wrAcqControl) begin
         acqControl_r <= regWrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fpControl_r <= FP_CONTROL_RST;
      end else if (wrFpControl) begin
         fpControl_r <= regWrData;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         groupMode_r <= GROUP_MODE_RST;
      end else if (wrGroupMode) begin
         groupMode_r <= regWrData[15:0]; // RL23
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pinLevel_r <= PIN_LEVEL_RST;
      end else if (wrPinLevel) begin
         pinLevel_r <= regWrData[15:0]; // RL2
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         threshold_r <= THRESHOLD_RST;
      end else if (wrThreshold) begin
         threshold_r <= regWrData[11:0]; // RL5
      end
   end

   // Pin level read: input groups show the sampled lines, output groups the
   // stored value, so a read-modify-write does not disturb driven lines.
   logic [15:0] pinReadback;
   for (genvar g = 0; g < GROUPS; g++) begin : gRd
      assign pinReadback[4*g +: 4] = groupDirOut[g] ? pinLevel_r[4*g +: 4] : lineSync[4*g +: 4]; // RL1
   end

   always_comb begin
      unique case (regAddr)
         ACQ_CONTROL_OFS: rdDataNxt = acqControl_r;
         FP_CONTROL_OFS: rdDataNxt = fpControl_r;
         GROUP_MODE_OFS: rdDataNxt = {16'h0000, groupMode_r};
         LVDS_PIN_LEVEL_OFS: rdDataNxt = {16'h0000, pinReadback};
         BUFFER_FULL_THRESHOLD_OFS: rdDataNxt = {20'h00000, threshold_r};
         default: rdDataNxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         regRdData <= '0;
         regRdValid <= 1'b0;
      end else begin
         regRdValid <= regRdEn;
         if (regRdEn) begin
            regRdData <= rdDataNxt;
         end
      end
   end
endmodule

/* File: dv/fplio_chk.sv */
// Checker for the front-panel line block, bound to its top module.
// Assumes the control registers change only through the register write strobe.
module fplio_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic [15:0] regAddr,
   input wire logic regWrEn,
   input wire logic regRdEn,
   input wire logic [31:0] regWrData,
   input wire logic regRdValid,
   input wire logic [15:0] lineIn,
   input wire logic [15:0] lineOut,
   input wire logic [15:0] lineOe,
   input wire logic [7:0] chanTrigReq,
   input wire logic memFullIn,
   input wire logic eventsStored,
   input wire logic globalTrig,
   input wire logic fireOutConnector,
   input wire logic runState,
   input wire logic memClear,
   input wire logic timeTagClear,
   input wire logic [31:0] eventTimeTag,
   input wire logic [15:0] eventPattern
);
   timeunit 1ns;
   timeprecision 1ps;
   import fplio_pkg::*;
   logic [31:0] fpCtl_r;
   logic [15:0] grpMode_r;
   logic [15:0] pinLvl_r;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   // Mirror of the mode registers, so each check knows which map is live.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         fpCtl_r <= 32'h0000_0000;
         grpMode_r <= 16'h0000;
         pinLvl_r <= 16'h0000;
      end else if (regWrEn) begin
         if (regAddr == FP_CONTROL_OFS) fpCtl_r <= regWrData;
         if (regAddr == GROUP_MODE_OFS) grpMode_r <= regWrData[15:0];
         if (regAddr == LVDS_PIN_LEVEL_OFS) pinLvl_r <= regWrData[15:0];
      end
   end
   chk_rd_answer: assert property (regRdEn |=> regRdValid)
      else $error("read strobe not answered");
   chk_legacy_map: assert property (!fpCtl_r[8] |=> lineOe == LEGACY_OE
      && lineOut == {4'hF, $past(runState), $past(globalTrig),
      $past(eventsStored), $past(memFullIn), $past(chanTrigReq)})
      else $error("default line map wrong");
   chk_reg_out: assert property (fpCtl_r[8] && fpCtl_r[2] && grpMode_r[3:0] == 4'h0 && !regWrEn
      |=> lineOut[3:0] == pinLvl_r[3:0] && lineOe[3:0] == 4'hF)
      else $error("register mode output wrong");
   chk_trig_groups: assert property (fpCtl_r[8] && fpCtl_r[3] && grpMode_r[7:4] == 4'h1
      |=> {lineOut[7:4], 4'h0} == ($past(chanTrigReq) & 8'hF0))
      else $error("trigger mode group wrong");
   chk_hs_outputs: assert property (fpCtl_r[8] && fpCtl_r[2] && grpMode_r[3:0] == 4'h2
      |=> lineOut[3] != $past(runState) && lineOut[2] != $past(fireOutConnector))
      else $error("handshake run or fire output wrong");
   chk_run_gates: assert property (fireOutConnector |-> $past(runState))
      else $error("trigger while not running");
   chk_veto_only: assert property (globalTrig |-> fireOutConnector)
      else $error("global trigger without connector trigger");
   chk_pattern_latch: assert property ($rose(globalTrig) |-> eventPattern == $past(lineIn, 3))
      else $error("pattern not latched with trigger");
   chk_sw_clear: assert property (regWrEn && regAddr == SW_CLEAR_OFS |-> ##[1:3] memClear)
      else $error("software clear gave no buffer clear");
   chk_tt_zero: assert property (timeTagClear |-> ##[0:2] eventTimeTag == 32'h0000_0000)
      else $error("time tag not reinitialised");
endmodule
bind fplio_top fplio_chk u_fplio_chk (
   .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
   .regWrData(regWrData), .regRdValid(regRdValid), .lineIn(lineIn), .lineOut(lineOut), .lineOe(lineOe),
   .chanTrigReq(chanTrigReq), .memFullIn(memFullIn), .eventsStored(eventsStored), .globalTrig(globalTrig),
   .fireOutConnector(fireOutConnector), .runState(runState), .memClear(memClear),
   .timeTagClear(timeTagClear), .eventTimeTag(eventTimeTag), .eventPattern(eventPattern)
);

/* File: dv/fplio_far_end.sv */
// Far-end board model: drives every line that the block leaves as input.
// Assumes one active-low request per group position, shown on all groups.
module fplio_far_end (
   input wire logic [15:0] pat,
   input wire logic [3:0] low,
   input wire logic [15:0] lineOut,
   input wire logic [15:0] lineOe,
   output logic [15:0] lineIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] farLevel;
   assign farLevel = pat & ~{4{low}};
   // A line the block drives carries the block's level to every receiver.
   assign lineIn = (lineOe & lineOut) | (~lineOe & farLevel);
endmodule

/* File: dv/fplio_top_bench.sv */
// Self-checking bench for the front-panel line block and a far-end model.
// Assumes reads answer one cycle after the strobe and no stall ever occurs.
module fplio_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import fplio_pkg::*;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic [15:0] regAddr = 16'h0000, pat = 16'hFFFF, lineIn, lineOut, lineOe, eventPattern;
   logic [31:0] regWrData = 32'h0000_0000, regRdData, eventTimeTag, rd;
   logic [7:0] chanTrigReq = 8'h00;
   logic [11:0] bufOccupancy = 12'h000;
   logic [3:0] low = 4'h0;
   logic regWrEn = 1'b0, regRdEn = 1'b0, srcTrigIn = 1'b0, memFullIn = 1'b0, eventsStored = 1'b0;
   logic regRdValid, globalTrig, fireOutConnector, runState, memClear, timeTagClear;
   logic [9:0] rowIn [3] = '{10'h0A5, 10'h15A, 10'h3FF};
   logic [15:0] rowOut [3] = '{16'hF0A5, 16'hF15A, 16'hF3FF};
   int n_errors = 0, num_checks = 0, cyc = 0, nTrig = 0, nFire = 0, nClr = 0, nTtc = 0, n0, f0;
   always #4 core_clk = ~core_clk;
   fplio_top u_fplio_top (
      .core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .lineIn(lineIn),
      .lineOut(lineOut), .lineOe(lineOe), .chanTrigReq(chanTrigReq), .srcTrigIn(srcTrigIn),
      .bufOccupancy(bufOccupancy), .memFullIn(memFullIn), .eventsStored(eventsStored),
      .globalTrig(globalTrig), .fireOutConnector(fireOutConnector), .runState(runState),
      .memClear(memClear), .timeTagClear(timeTagClear), .eventTimeTag(eventTimeTag),
      .eventPattern(eventPattern)
   );
   fplio_far_end u_fplio_far_end (.pat(pat), .low(low), .lineOut(lineOut), .lineOe(lineOe), .lineIn(lineIn));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Pulse counters let each test judge strobes without racing their edge.
   always @(posedge core_clk) begin
      cyc++;
      nTrig += int'(globalTrig);
      nFire += int'(fireOutConnector);
      nClr += int'(memClear);
      nTtc += int'(timeTagClear);
      if (cyc == 2000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      wt(1);
      regWrEn = 1'b0;
      wt(1);
   endtask
   task automatic rdr(input logic [15:0] a);
      regAddr = a;
      regRdEn = 1'b1;
      wt(1);
      regRdEn = 1'b0;
      chk("rdValid", 32'h1, 32'(regRdValid));
      rd = regRdData;
      wt(1);
   endtask
   initial begin
      wt(16);
      chk("rstOut", 32'h0000_FFFF, 32'(lineOut));
      chk("rstOe", 32'h0000_0FFF, 32'(lineOe));
      resetn = 1'b1;
      wt(2);
      foreach (rowIn[i]) begin
         {eventsStored, memFullIn, chanTrigReq} = rowIn[i];
         wt(2);
         chk("defaultMap", 32'(rowOut[i]), 32'(lineOut));
      end
      rdr(16'h8004);
      chk("unmapped", 32'h0, rd);
      $display("done reset and default map");
      wr(FP_CONTROL_OFS, 32'h0000_0104);
      wr(LVDS_PIN_LEVEL_OFS, 32'h0000_FFF5);
      pat = 16'hA5C3;
      wt(4);
      chk("regOut", 32'h0000_FFF5, 32'(lineOut));
      chk("regOe", 32'h0000_000F, 32'(lineOe));
      rdr(LVDS_PIN_LEVEL_OFS);
      chk("regIn", 32'h0000_A5C5, rd);
      pat = 16'hFFFF;
      chanTrigReq = 8'h3C;
      wr(FP_CONTROL_OFS, 32'h0000_013C);
      wr(GROUP_MODE_OFS, 32'h0000_1111);
      wt(2);
      chk("trigMode", 32'h0000_3C3C, 32'(lineOut));
      $display("done register and trigger modes");
      {eventsStored, memFullIn, chanTrigReq} = 10'h000;
      wr(BUFFER_FULL_THRESHOLD_OFS, 32'h0000_0010);
      wr(FP_CONTROL_OFS, 32'h0000_0105);
      wr(GROUP_MODE_OFS, 32'h0000_0022);
      wr(ACQ_CONTROL_OFS, 32'h0000_0304);
      wt(4);
      chk("hsIdle", 32'h7, 32'(lineOut[3:0]));
      bufOccupancy = 12'h010;
      wt(4);
      chk("nearFull", 32'h6, 32'(lineOut[3:0]));
      bufOccupancy = 12'h00F;
      low = 4'h1;
      wt(5);
      chk("holdOff", 32'h6, 32'(lineOut[3:0]));
      low = 4'h2;
      wt(5);
      chk("vetoOut", 32'h5, 32'(lineOut[3:0]));
      n0 = nTrig;
      f0 = nFire;
      srcTrigIn = 1'b1;
      wt(1);
      srcTrigIn = 1'b0;
      wt(4);
      chk("vetoed", 32'(n0), 32'(nTrig));
      chk("fireOut", 32'(f0 + 1), 32'(nFire));
      low = 4'h0;
      wt(5);
      n0 = nTrig;
      low = 4'h4;
      wt(5);
      chk("extFire", 32'(n0 + 1), 32'(nTrig));
      chk("pattern", 32'h0000_BBB7, 32'(eventPattern));
      low = 4'h0;
      wr(ACQ_CONTROL_OFS, 32'h0000_0003);
      low = 4'h8;
      wt(5);
      chk("goLevel", 32'h1, 32'(runState));
      low = 4'h0;
      wt(5);
      chk("goOff", 32'h0, 32'(runState));
      wr(ACQ_CONTROL_OFS, 32'h0000_0803);
      low = 4'h8;
      wt(3);
      low = 4'h0;
      wt(5);
      chk("goEdge", 32'h1, 32'(runState));
      $display("done handshake mode");
      wr(BUFFER_FULL_THRESHOLD_OFS, 32'h0000_0000);
      wr(GROUP_MODE_OFS, 32'h0000_3003);
      wr(FP_CONTROL_OFS, 32'h0000_0104);
      wr(ACQ_CONTROL_OFS, 32'h0000_0004);
      {eventsStored, memFullIn} = 2'b11;
      wt(4);
      chk("legacyOut", 32'hB, 32'(lineOut[3:0]));
      srcTrigIn = 1'b1;
      wt(1);
      srcTrigIn = 1'b0;
      wt(1);
      chk("legacyTrig", 32'hF, 32'(lineOut[3:0]));
      n0 = nTtc;
      low = 4'h1;
      wt(6);
      chk("tsClear", 32'(n0 + 1), 32'(nTtc));
      chk("timeTag", 32'h0000_0003, eventTimeTag);
      low = 4'h0;
      n0 = nClr;
      wr(SW_CLEAR_OFS, 32'h0000_0001);
      wt(3);
      chk("swClear", 32'(n0 + 1), 32'(nClr));
      wr(FP_CONTROL_OFS, 32'h0000_0000);
      pat = 16'hDFFF;
      wt(6);
      chk("pinClear", 32'(n0 + 2), 32'(nClr));
      $display("done legacy mode and clears");
      pat = 16'hFFFF;
      resetn = 1'b0;
      wt(3);
      chk("midRstOut", 32'h0000_FFFF, 32'(lineOut));
      chk("midRstRun", 32'h0, 32'(runState));
      resetn = 1'b1;
      wt(2);
      chk("postRstMap", 32'h0000_F300, 32'(lineOut));
      $display("done mid-run reset");
      stop_test();
   end
endmodule
